// ==== jcr_defines.svh ====
/*
 jtag_config_readback constants: tap walk counts, opcodes, packet words,
 clock divider. Assumes a 100 MHz system clock.
*/
`ifndef JCR_DEFINES_SVH
`define JCR_DEFINES_SVH
`define JCR_CLK_MHZ 100
`define JCR_TCK_NS 100
`define JCR_TCK_HALF ((`JCR_TCK_NS * `JCR_CLK_MHZ) / 2000)
`define JCR_OP_SHUTDOWN 6'h0d
`define JCR_OP_CFG_WRITE 6'h05
`define JCR_OP_CFG_READ 6'h04
`define JCR_OP_BITS 5
`define JCR_RESET_CLKS 5
`define JCR_RTI_CLKS 12
`define JCR_PKT_CLKS 287
`define JCR_PKT_LAST 287
`define JCR_PKT_WORDS 9
`define JCR_SYNC_WORD 32'haa995566
`define JCR_HDR_FAR_WR 32'h30002001
`define JCR_START_ADDR 32'h00000000
`define JCR_HDR_CMD_WR 32'h30008001
`define JCR_CMD_READBACK 32'h00000007
`define JCR_HDR_FRO_RD 32'h28006000
`define JCR_HDR_TYPE2 32'h40002922
`define JCR_PAD_WORD 32'h20000000
`define JCR_READ_WORDS 10530
`define JCR_LAST_STEP 25
`endif

// ==== jcr_pkg.sv ====
/*
 jtag_config_readback types. Assumes jcr_defines.svh for the numbers.
*/
`default_nettype none
package jcr_pkg;
    typedef enum logic [1:0] {
        JCR_IDLE = 2'b00,
        JCR_RUN = 2'b01,
        JCR_DONE = 2'b11
    } jcr_state_t;
    typedef enum logic [1:0] {
        JCR_SRC_ZERO = 2'b00,
        JCR_SRC_OPCODE = 2'b01,
        JCR_SRC_PACKET = 2'b10,
        JCR_SRC_CAPTURE = 2'b11
    } jcr_src_t;
endpackage
`default_nettype wire

// ==== jcr_readback_host.sv ====
/*
 jtag_config_readback host: walks a device tap through shutdown, packet
 load and frame readout, and queues the readback words in a fifo.
 Assumes the device tap follows standard state transitions; tdo_i is
 asynchronous and tck_o is made here by dividing clock_i.
*/
// Summary of operation
// - shift five shutdown opcode bits lsb first, tms low.
// - last ir bit zero with tms high, then one more tms-high clock.
// - twelve tck in run-test-idle while the device shuts down.
// - from idle: two tms-high then two tms-low clocks to shift-ir.
// - five config-write opcode bits lsb first, last zero with tms high.
// - from ir exit: two tms-high, two tms-low clocks to shift-dr.
// - packets msb first: sync word, address header, zero start address.
// - command header, readback command, then frame readout read header.
// - type-two word count header, then pad words end the stream.
// - 287 packet bits tms low, final zero bit with tms high.
// - after shift-dr: three tms-high, two tms-low clocks to shift-ir.
// - five config-read opcode bits lsb first, last zero with tms high.
// - readout shifts one tdo bit per clock, tms low, tdi ignored.
// - last readout bit arrives with tms high; then three high, two low.
// - read one extra frame; host discards the first frame.
// - start with five tms-high clocks, then one tms-low into idle.
`timescale 1ns/1ps
`default_nettype none
`include "jcr_defines.svh"

module jcr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic full_reg, full_next, empty_reg, empty_next;
    logic do_wr, do_rd;

    always_comb begin
        do_wr = in_valid_i && !full_reg;
        do_rd = out_ready_i && !empty_reg;
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        if (do_wr) begin
            wptr_next = (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
        end
        if (do_rd) begin
            rptr_next = (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
        end
        cnt_next = cnt_reg + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
        full_next = (cnt_next == (AW+1)'(DEPTH));
        empty_next = (cnt_next == '0);
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
            full_reg <= 1'b0;
            empty_reg <= 1'b1;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg <= cnt_next;
            full_reg <= full_next;
            empty_reg <= empty_next;
        end
    end

    // storage has no reset; empty_reg guards every read
    always_ff @(posedge clock_i) begin
        if (do_wr) begin
            mem[wptr_reg] <= in_data_i;
        end
    end

    assign in_ready_o = !full_reg;
    assign out_valid_o = !empty_reg;
    assign out_data_o = mem[rptr_reg];
endmodule // jcr_fifo

module jcr_readback_host #(
    parameter int READ_WORDS = `JCR_READ_WORDS,
    parameter int FRAME_WORDS = 32,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    output logic [31:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic rd_ready_i
);
    localparam int CW = 24;
    localparam logic [7:0] HALF = 8'(`JCR_TCK_HALF);
    localparam logic [CW-1:0] READ_BITS = CW'(READ_WORDS * 32);
    localparam logic [5:0] OP_SHD = `JCR_OP_SHUTDOWN;
    localparam logic [31:0] SYNC_W = `JCR_SYNC_WORD;
    logic busy_reg, busy_next;

    jcr_pkg::jcr_state_t state_reg, state_next;
    logic [4:0] step_reg, step_next;
    logic [CW-1:0] bit_reg, bit_next;
    logic [7:0] div_reg, div_next;
    logic tck_reg, tck_next, tms_reg, tms_next, tdi_reg, tdi_next;
    logic done_reg, done_next;
    logic [31:0] sh_reg, sh_next;
    logic [CW-1:0] word_reg, word_next;
    logic [2:0] tdo_sync_reg;
    logic tdo_val_reg;
    logic push, fifo_ready;
    logic [31:0] push_data;

    // tms level, tdi source and clock count of each walk step
    function automatic logic step_tms(input logic [4:0] s);
        unique case (s)
            5'd0, 5'd2, 5'd5, 5'd6, 5'd8, 5'd11, 5'd12, 5'd15, 5'd16,
            5'd19, 5'd20, 5'd23, 5'd24: step_tms = 1'b1;
            default: step_tms = 1'b0;
        endcase
    endfunction

    function automatic jcr_pkg::jcr_src_t step_src(input logic [4:0] s);
        unique case (s)
            5'd4, 5'd10, 5'd18: step_src = jcr_pkg::JCR_SRC_OPCODE;
            5'd14, 5'd15: step_src = jcr_pkg::JCR_SRC_PACKET;
            5'd22, 5'd23: step_src = jcr_pkg::JCR_SRC_CAPTURE;
            default: step_src = jcr_pkg::JCR_SRC_ZERO;
        endcase
    endfunction

    function automatic logic [CW-1:0] step_len(input logic [4:0] s);
        unique case (s)
            5'd0: step_len = CW'(`JCR_RESET_CLKS);
            5'd2, 5'd3, 5'd8, 5'd9, 5'd12, 5'd13, 5'd17, 5'd20, 5'd21,
            5'd25: step_len = CW'(2);
            5'd4, 5'd10, 5'd18: step_len = CW'(`JCR_OP_BITS);
            5'd7: step_len = CW'(`JCR_RTI_CLKS);
            5'd14: step_len = CW'(`JCR_PKT_CLKS);
            5'd16, 5'd24: step_len = CW'(3);
            5'd22: step_len = READ_BITS - 1'b1;
            default: step_len = CW'(1);
        endcase
    endfunction

    function automatic logic [31:0] pkt_word(input logic [3:0] w);
        unique case (w)
            4'd0: pkt_word = `JCR_SYNC_WORD;
            4'd1: pkt_word = `JCR_HDR_FAR_WR;
            4'd2: pkt_word = `JCR_START_ADDR;
            4'd3: pkt_word = `JCR_HDR_CMD_WR;
            4'd4: pkt_word = `JCR_CMD_READBACK;
            4'd5: pkt_word = `JCR_HDR_FRO_RD;
            4'd6: pkt_word = `JCR_HDR_TYPE2;
            default: pkt_word = `JCR_PAD_WORD;
        endcase
    endfunction

    function automatic logic step_tdi(input logic [4:0] s,
                                      input logic [CW-1:0] b);
        logic [CW-1:0] pb;
        logic [5:0] op;
        logic [31:0] pw;
        pb = (s == 5'd15) ? CW'(`JCR_PKT_LAST) : b;
        op = (s == 5'd4) ? `JCR_OP_SHUTDOWN :
             (s == 5'd10) ? `JCR_OP_CFG_WRITE : `JCR_OP_CFG_READ;
        pw = pkt_word(pb[8:5]);
        unique case (step_src(s))
            jcr_pkg::JCR_SRC_OPCODE: step_tdi = op[b[2:0]];
            jcr_pkg::JCR_SRC_PACKET:
                step_tdi = pw[5'd31 - pb[4:0]];
            default: step_tdi = 1'b0;
        endcase
    endfunction

    // tdo changes only once two synchroniser stages agree
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tdo_sync_reg <= 3'h0;
            tdo_val_reg <= 1'b0;
        end else begin
            tdo_sync_reg <= {tdo_sync_reg[1:0], tdo_i};
            if (tdo_sync_reg[1] == tdo_sync_reg[2]) begin
                tdo_val_reg <= tdo_sync_reg[2];
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        step_next = step_reg;
        bit_next = bit_reg;
        div_next = div_reg;
        tck_next = tck_reg;
        tms_next = tms_reg;
        tdi_next = tdi_reg;
        sh_next = sh_reg;
        word_next = word_reg;
        done_next = 1'b0;
        push = 1'b0;
        push_data = {sh_reg[30:0], tdo_val_reg};
        unique case (state_reg)
            jcr_pkg::JCR_IDLE: begin
                if (start_i) begin
                    state_next = jcr_pkg::JCR_RUN;
                    step_next = 5'd0;
                    bit_next = '0;
                    div_next = 8'h00;
                    word_next = '0;
                    tck_next = 1'b0;
                    tms_next = step_tms(5'd0);
                    tdi_next = 1'b0;
                end
            end
            jcr_pkg::JCR_RUN: begin
                if (div_reg != HALF - 1'b1) begin
                    div_next = div_reg + 1'b1;
                end else if (!tck_reg) begin
                    // in readout steps tck is held low while the fifo cannot take a word
                    if (step_src(step_reg) != jcr_pkg::JCR_SRC_CAPTURE ||
                        fifo_ready) begin
                        tck_next = 1'b1;
                        div_next = 8'h00;
                        if (step_src(step_reg) == jcr_pkg::JCR_SRC_CAPTURE)
                        begin
                            sh_next = push_data;
                            if (bit_reg[4:0] == 5'h1f ||
                                step_reg == 5'd23) begin
                                word_next = word_reg + 1'b1;
                                push = (word_reg >= CW'(FRAME_WORDS));
                            end
                        end
                    end
                end else begin
                    tck_next = 1'b0;
                    div_next = 8'h00;
                    if (bit_reg == step_len(step_reg) - 1'b1) begin
                        bit_next = '0;
                        if (step_reg == 5'(`JCR_LAST_STEP)) begin
                            state_next = jcr_pkg::JCR_DONE;
                            step_next = step_reg;
                        end else begin
                            step_next = step_reg + 1'b1;
                        end
                    end else begin
                        bit_next = bit_reg + 1'b1;
                    end
                    // tms and tdi change only in the low half of tck
                    tms_next = (state_next == jcr_pkg::JCR_DONE) ? 1'b0 :
                               step_tms(step_next);
                    tdi_next = (state_next == jcr_pkg::JCR_DONE) ? 1'b0 :
                               step_tdi(step_next, bit_next);
                end
            end
            jcr_pkg::JCR_DONE: begin
                state_next = jcr_pkg::JCR_IDLE;
                done_next = 1'b1;
            end
            default: state_next = jcr_pkg::JCR_IDLE;
        endcase
        busy_next = (state_next == jcr_pkg::JCR_RUN);
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= jcr_pkg::JCR_IDLE;
            step_reg <= 5'd0;
            bit_reg <= '0;
            div_reg <= 8'h00;
            tck_reg <= 1'b0;
            tms_reg <= 1'b1;
            tdi_reg <= 1'b0;
            sh_reg <= 32'h00000000;
            word_reg <= '0;
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            step_reg <= step_next;
            bit_reg <= bit_next;
            div_reg <= div_next;
            tck_reg <= tck_next;
            tms_reg <= tms_next;
            tdi_reg <= tdi_next;
            sh_reg <= sh_next;
            word_reg <= word_next;
            done_reg <= done_next;
            busy_reg <= busy_next;
        end
    end

    jcr_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(push),
        .in_ready_o(fifo_ready),
        .in_data_i(push_data),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_ready_i),
        .out_data_o(rd_data_o)
    );

    assign tck_o = tck_reg;
    assign tms_o = tms_reg;
    assign tdi_o = tdi_reg;
    assign busy_o = busy_reg;
    assign done_o = done_reg;

    wire running = (state_reg == jcr_pkg::JCR_RUN);

    a_tms_low_phase: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        $changed(tms_reg) && running |-> !tck_reg)
        else $error("tms changed while tck high");
    a_reset_walk: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        running && step_reg == 5'd0 |-> tms_reg && !tdi_reg)
        else $error("reset walk tms not high");
    a_ir_exit_bit: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        running && (step_reg == 5'd5 || step_reg == 5'd19)
        |-> tms_reg && !tdi_reg)
        else $error("ir exit bit wrong");
    a_rti_hold: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        running && step_reg == 5'd7 |-> !tms_reg)
        else $error("tms high during shutdown wait");
    a_shutdown_op: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        running && step_reg == 5'd4 && tck_reg
        |-> !tms_reg && tdi_reg == OP_SHD[bit_reg[2:0]])
        else $error("shutdown opcode bit wrong");
    a_sync_first: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        running && step_reg == 5'd14 && bit_reg < CW'(32) && tck_reg
        |-> tdi_reg == SYNC_W[5'd31 - bit_reg[4:0]])
        else $error("sync word bit wrong");
    a_pkt_exit: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        running && step_reg == 5'd15 |-> tms_reg && !tdi_reg)
        else $error("packet exit bit wrong");
    a_read_tms: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        running && step_reg == 5'd22 |-> !tms_reg && !tdi_reg)
        else $error("readout tms not low");
    a_read_exit: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        running && step_reg == 5'd23 |-> tms_reg)
        else $error("last readout bit without tms high");
    a_pad_discard: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        push |-> word_reg >= CW'(FRAME_WORDS))
        else $error("pad frame word queued");
    a_stall_full: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        running && !fifo_ready && step_src(step_reg) ==
        jcr_pkg::JCR_SRC_CAPTURE && !tck_reg |=> !tck_reg)
        else $error("tck rose while fifo full");
endmodule // jcr_readback_host
`default_nettype wire

// ==== jcr_tap_model.sv ====
/*
 Behavioural device tap that faces the readback host, with its logs.
 Assumes tck_i comes from the host and stands low between frames.
*/
`timescale 1ns/1ps
`default_nettype none
`include "jcr_defines.svh"
module jcr_tap_model #(
    parameter int PAD_WORDS = 2
) (
    input wire logic arst_n_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic [31:0] salt_i,
    output logic tdo_o,
    output logic done_pin_o
);
    localparam logic [3:0] TLR = 4'h0;
    localparam logic [3:0] RTI = 4'h1;
    localparam logic [3:0] SHD = 4'h4;
    localparam logic [3:0] SHI = 4'hb;
    localparam logic [3:0] UIR = 4'hf;
    // next state by tms value, indexed by the present state
    localparam logic [3:0] GO0 [16] = '{4'h1, 4'h1, 4'h3, 4'h4, 4'h4, 4'h6,
        4'h6, 4'h4, 4'h1, 4'ha, 4'hb, 4'hb, 4'hd, 4'hd, 4'hb, 4'h1};
    localparam logic [3:0] GO1 [16] = '{4'h0, 4'h2, 4'h9, 4'h5, 4'h5, 4'h8,
        4'h7, 4'h8, 4'h2, 4'h0, 4'hc, 4'hc, 4'hf, 4'he, 4'hf, 4'h2};
    // starts mid-shift so the host's reset walk is really needed
    logic [3:0] st = SHD;
    logic [3:0] nxt;
    logic [5:0] ir = 6'h00;
    logic [5:0] ir_sh = 6'h00;
    logic [5:0] ir_q [$];
    logic wr_q [$];
    logic [31:0] cur;
    logic synced = 1'b0;
    logic seen_low = 1'b0;
    int lead_ones = 0;
    int rti_pre = 0;
    int rti_cnt = 0;
    int rd_bits = 0;

    function automatic logic [31:0] rb_word(input int k);
        // the frame buffer's leading pad frame carries no data
        return (k < PAD_WORDS) ? 32'h0 :
            salt_i + 32'(k) * 32'h9e3779b9;
    endfunction

    assign done_pin_o = !(ir == `JCR_OP_SHUTDOWN && rti_cnt < 12);

    always @(posedge tck_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ir_q.delete();
            wr_q.delete();
            synced = 1'b0;
            seen_low = 1'b0;
            lead_ones = 0;
            rti_pre = 0;
            rti_cnt = 0;
            rd_bits = 0;
        end else begin
            if (!seen_low && tms_i) lead_ones++;
            if (!tms_i) seen_low = 1'b1;
            if (st == TLR) begin
                synced = 1'b1;
                ir = 6'h00;
            end
            if (st == SHI) ir_sh = {tdi_i, ir_sh[5:1]};
            if (st == SHD && ir == `JCR_OP_CFG_WRITE) wr_q.push_back(tdi_i);
            if (st == SHD && ir == `JCR_OP_CFG_READ) rd_bits++;
            if (st == UIR && synced) begin
                ir = ir_sh;
                ir_q.push_back(ir_sh);
            end
            nxt = tms_i ? GO1[st] : GO0[st];
            if (nxt == RTI && synced && ir_q.size() == 0) rti_pre++;
            if (nxt == RTI && synced && ir == `JCR_OP_SHUTDOWN) begin
                rti_cnt++;
            end
            st = nxt;
        end
    end

    initial tdo_o = 1'b0;
    always @(negedge tck_i) begin
        if (st == SHD && ir == `JCR_OP_CFG_READ) begin
            cur = rb_word(rd_bits / 32);
            tdo_o = cur[31 - (rd_bits % 32)];
        end else begin
            // released line: show no stale value
            tdo_o = ~tdo_o;
        end
    end
endmodule // jcr_tap_model
`default_nettype wire

// ==== test_jtag_config_readback.sv ====
/*
 Self-checking bench for the readback host against the tap model.
 Assumes jcr_tap_model logs what the host shifts into the device.
*/
`timescale 1ns/1ps
`default_nettype none
module test_jtag_config_readback;
    localparam int READ_W = 12;
    localparam int FRAME_W = 2;
    localparam int DEPTH = 8;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic start_i = 1'b0;
    logic rd_ready_i = 1'b0;
    logic [31:0] salt = 32'h0;
    logic busy, done, tck, tms, tdi, tdo, rd_valid;
    logic [31:0] rd_data;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [31:0] pkt [9] = '{32'haa995566, 32'h30002001, 32'h00000000,
        32'h30008001, 32'h00000007, 32'h28006000, 32'h40002922,
        32'h20000000, 32'h20000000};
    logic [5:0] ops [3] = '{6'h0d, 6'h05, 6'h04};

    always #5 clock_i = ~clock_i;

    jcr_readback_host #(
        .READ_WORDS(READ_W),
        .FRAME_WORDS(FRAME_W),
        .FIFO_DEPTH(DEPTH)
    ) uut (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .start_i(start_i),
        .busy_o(busy), .done_o(done), .tck_o(tck), .tms_o(tms),
        .tdi_o(tdi), .tdo_i(tdo), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .rd_ready_i(rd_ready_i)
    );

    jcr_tap_model #(.PAD_WORDS(FRAME_W)) mdl (
        .arst_n_i(arst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .salt_i(salt), .tdo_o(tdo), .done_pin_o()
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    function automatic logic [31:0] exp_word(input int k);
        return salt + 32'(k) * 32'h9e3779b9;
    endfunction

    task automatic close_out();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // stall: hold the reader off until the buffer refuses, then drain
    task automatic run(input bit stall);
        int got_n;
        int guard;
        bit seen_done;
        logic [31:0] w;
        arst_n_i = 1'b0;
        rd_ready_i = 1'b0;
        repeat (12) @(negedge clock_i);
        check({27'h0, tck, tms, busy, done, rd_valid}, 32'h8);
        arst_n_i = 1'b1;
        salt = $urandom();
        start_i = 1'b1;
        @(negedge clock_i);
        start_i = 1'b0;
        check({29'h0, busy, tms, tck}, 32'h6);
        repeat (60) @(negedge clock_i);
        // a start while busy must not launch a second walk
        start_i = 1'b1;
        @(negedge clock_i);
        start_i = 1'b0;
        guard = 0;
        while (stall && mdl.rd_bits < (FRAME_W + DEPTH) * 32 &&
               guard < 20000) begin
            @(negedge clock_i);
            guard++;
        end
        if (stall) begin
            repeat (400) @(negedge clock_i);
            check(32'(mdl.rd_bits), 32'((FRAME_W + DEPTH) * 32));
        end
        got_n = 0;
        seen_done = 1'b0;
        guard = 0;
        while ((got_n < READ_W - FRAME_W || !seen_done) && guard < 40000) begin
            @(negedge clock_i);
            guard++;
            if (done === 1'b1) seen_done = 1'b1;
            rd_ready_i = 1'($urandom_range(1));
            if (rd_ready_i && rd_valid === 1'b1) begin
                check(rd_data, exp_word(got_n + FRAME_W));
                got_n++;
            end
        end
        check(32'(got_n), 32'(READ_W - FRAME_W));
        check({31'h0, seen_done}, 32'h1);
        @(negedge clock_i);
        check({30'h0, busy, rd_valid}, 32'h0);
        check(32'(mdl.ir_q.size()), 32'h3);
        for (int i = 0; i < 3 && i < mdl.ir_q.size(); i++) begin
            check({26'h0, mdl.ir_q[i]}, {26'h0, ops[i]});
        end
        check(32'(mdl.lead_ones), 32'h5);
        check(32'(mdl.rti_pre), 32'h1);
        check(32'(mdl.rti_cnt), 32'h0c);
        check(32'(mdl.wr_q.size()), 32'h120);
        for (int i = 0; i < 9 && mdl.wr_q.size() == 288; i++) begin
            w = 32'h0;
            for (int b = 0; b < 32; b++) w = {w[30:0], mdl.wr_q[i * 32 + b]};
            check(w, pkt[i]);
        end
        check(32'(mdl.rd_bits), 32'(READ_W * 32));
        check({28'h0, mdl.st}, 32'hb);
    endtask

    initial begin
        void'($urandom(16458));
        run(1'b1);
        run(1'b0);
        close_out();
    end

    initial begin
        repeat (60000) @(posedge clock_i);
        error_cnt++;
        close_out();
    end
endmodule // test_jtag_config_readback
`default_nettype wire
